/* File: copper_irq_pkg.sv */
// Constants for the copper event enable/status register block
// Assumes an AXI4-Lite master with 32-bit data
`default_nettype none
package copper_irq_pkg;
  // Register indices (printed offsets are not multiples of four)
  localparam logic [7:0] ENABLE_IDX = 8'h12;
  localparam logic [7:0] STATUS_IDX = 8'h13;
  // Own register index for soft reset and global indication
  localparam logic [7:0] CONTROL_IDX = 8'h17;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ENABLE_ADDR = ADDR_W'(ENABLE_IDX * 4);
  localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'(STATUS_IDX * 4);
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = ADDR_W'(CONTROL_IDX * 4);
  // Field positions
  localparam int BIT_ANEG_ERR = 15;
  localparam int BIT_SPEED = 14;
  localparam int BIT_DUPLEX = 13;
  localparam int BIT_PAGE = 12;
  localparam int BIT_ANEG_DONE = 11;
  localparam int BIT_LINK = 10;
  localparam int BIT_SYMBOL = 9;
  localparam int BIT_FALSE_CARRIER = 8;
  localparam int BIT_CROSSOVER = 6;
  localparam int BIT_ENERGY = 4;
  localparam int BIT_NO_LINK = 3;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_JABBER = 0;
  localparam int BIT_SOFT_RESET = 0;
  // Implemented event bits; 7, 5 and 2 are reserved
  localparam logic [15:0] EVENT_MASK = 16'hFF5B;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: copper_phy_interrupt_regs.sv */
// Copper event enable and latched status registers on AXI4-Lite
// Assumes event inputs are on clk; real-time levels come from pins
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Enable bit 1 passes its event to the interrupt request; 0 blocks it.
// - Enables clear on hardware reset, survive soft reset.
// - Bit 15 latches any auto-negotiation error condition.
// - Bit 14 latches on resolved speed change.
// - Bit 13 latches on resolved duplex change.
// - Bit 12 latches on page received.
// - Bit 11 latches on auto-negotiation completion.
// - Bit 10 latches on link status change either way.
// - Bits 9, 8, 0 latch symbol error, false carrier, jabber.
// - Bit 6 latches on crossover state change.
// - Bit 4 latches on energy-detect state change.
// - Bit 3 latches when page exchange ends without link.
// - Bit 1 latches on receive polarity change.
// - Status bits clear on hardware and soft reset.
// - Global interrupt output while any enabled status bit is pending.
module copper_phy_interrupt_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [copper_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [copper_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic anegErrorEvt,
  input wire logic [1:0] speedLevel,
  input wire logic duplexLevel,
  input wire logic pageReceivedEvt,
  input wire logic anegCompleteEvt,
  input wire logic linkLevel,
  input wire logic symbolErrorEvt,
  input wire logic falseCarrierEvt,
  input wire logic crossoverLevel,
  input wire logic energySleepLevel,
  input wire logic flpNoLinkEvt,
  input wire logic polarityLevel,
  input wire logic jabberEvt,
  output logic irqActive
);
  import copper_irq_pkg::*;

  // ----------------------------------------
  // Level synchronisers and change detect
  // ----------------------------------------
  localparam int LVL_W = 7;
  logic [LVL_W-1:0] lvlMeta_ff, lvlSync_ff, lvlLast_ff;
  logic [LVL_W-1:0] nxt_lvlMeta, nxt_lvlSync, nxt_lvlLast;
  logic [2:0] lvlValid_ff, nxt_lvlValid;
  logic [LVL_W-1:0] lvlChange;

  always_comb begin
    nxt_lvlMeta = {speedLevel, duplexLevel, linkLevel, crossoverLevel, energySleepLevel, polarityLevel};
    nxt_lvlSync = lvlMeta_ff;
    nxt_lvlLast = lvlSync_ff;
    nxt_lvlValid = {lvlValid_ff[1:0], 1'b1};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvlMeta_ff <= '0;
      lvlSync_ff <= '0;
      lvlLast_ff <= '0;
      lvlValid_ff <= 3'h0;
    end else begin
      lvlMeta_ff <= nxt_lvlMeta;
      lvlSync_ff <= nxt_lvlSync;
      lvlLast_ff <= nxt_lvlLast;
      lvlValid_ff <= nxt_lvlValid;
    end
  end

  // No change reported until the history register holds a real sample
  assign lvlChange = lvlValid_ff[2] ? (lvlSync_ff ^ lvlLast_ff) : '0;

  // ----------------------------------------
  // Event vector
  // ----------------------------------------
  logic [15:0] events;
  always_comb begin
    events = 16'h0000;
    events[BIT_ANEG_ERR] = anegErrorEvt;
    events[BIT_SPEED] = |lvlChange[6:5];
    events[BIT_DUPLEX] = lvlChange[4];
    events[BIT_PAGE] = pageReceivedEvt;
    events[BIT_ANEG_DONE] = anegCompleteEvt;
    events[BIT_LINK] = lvlChange[3];
    events[BIT_SYMBOL] = symbolErrorEvt;
    events[BIT_FALSE_CARRIER] = falseCarrierEvt;
    events[BIT_CROSSOVER] = lvlChange[2];
    events[BIT_ENERGY] = lvlChange[1];
    events[BIT_NO_LINK] = flpNoLinkEvt;
    events[BIT_POLARITY] = lvlChange[0];
    events[BIT_JABBER] = jabberEvt;
  end

  // ----------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------
  logic [15:0] enable_ff, nxt_enable;
  logic [15:0] status_ff, nxt_status;
  logic softReset_ff, nxt_softReset;
  logic awHeld_ff, nxt_awHeld;
  logic [ADDR_W-1:0] awAddr_ff, nxt_awAddr;
  logic wHeld_ff, nxt_wHeld;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;
  logic irq_ff, nxt_irq;
  logic awReady_ff, wReady_ff, arReady_ff;
  logic nxt_awReady, nxt_wReady, nxt_arReady;
  logic doWrite, doRead, statusRead;

  assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
  assign doRead = s_axi_arvalid && arReady_ff;
  assign statusRead = doRead && (s_axi_araddr == STATUS_ADDR);

  always_comb begin
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld = wHeld_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    nxt_enable = enable_ff;
    nxt_softReset = 1'b0;
    nxt_status = status_ff;
    if (s_axi_awvalid && awReady_ff) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_ff) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = RESP_OKAY;
      if (awAddr_ff == ENABLE_ADDR) begin
        // Reserved bits are software's to keep at zero
        if (wStrb_ff[0]) nxt_enable[7:0] = wData_ff[7:0];
        if (wStrb_ff[1]) nxt_enable[15:8] = wData_ff[15:8];
      end else if (awAddr_ff == CONTROL_ADDR) begin
        nxt_softReset = wStrb_ff[0] && wData_ff[BIT_SOFT_RESET];
      end else if (awAddr_ff == STATUS_ADDR) begin
        nxt_bResp = RESP_OKAY;
      end else begin
        nxt_bResp = RESP_SLVERR;
      end
    end else if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (doRead) begin
      nxt_rValid = 1'b1;
      nxt_rResp = RESP_OKAY;
      if (s_axi_araddr == ENABLE_ADDR) begin
        nxt_rData = {16'h0000, enable_ff};
      end else if (s_axi_araddr == STATUS_ADDR) begin
        nxt_rData = {16'h0000, status_ff};
      end else if (s_axi_araddr == CONTROL_ADDR) begin
        nxt_rData = {30'h0000000, irq_ff, 1'b0};
      end else begin
        nxt_rData = 32'h00000000;
        nxt_rResp = RESP_SLVERR;
      end
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
    // Read clears, but an event in the same cycle sets again
    if (statusRead) nxt_status = 16'h0000;
    nxt_status = (nxt_status | events) & EVENT_MASK;
    // Soft reset clears status, keeps enables
    if (softReset_ff) nxt_status = STATUS_RESET;
    // Enabled pending events drive the request
    nxt_irq = |(status_ff & enable_ff);
    // Ready is registered: high while the slot is free
    nxt_awReady = !nxt_awHeld && !(s_axi_awvalid && awReady_ff);
    nxt_wReady = !nxt_wHeld && !(s_axi_wvalid && wReady_ff);
    nxt_arReady = !nxt_rValid && !(s_axi_arvalid && arReady_ff);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_ff <= ENABLE_RESET;
      status_ff <= STATUS_RESET;
      softReset_ff <= 1'b0;
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= RESP_OKAY;
      irq_ff <= 1'b0;
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      arReady_ff <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
      status_ff <= nxt_status;
      softReset_ff <= nxt_softReset;
      awHeld_ff <= nxt_awHeld;
      awAddr_ff <= nxt_awAddr;
      wHeld_ff <= nxt_wHeld;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
      irq_ff <= nxt_irq;
      awReady_ff <= nxt_awReady;
      wReady_ff <= nxt_wReady;
      arReady_ff <= nxt_arReady;
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign irqActive = irq_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_irqFollows;
    @(posedge clk) disable iff (rst) |(status_ff & enable_ff) |=> irqActive;
  endproperty
  a_irqFollows: assert property (p_irqFollows) else $error("irq not raised for enabled event");
  property p_irqMasked;
    @(posedge clk) disable iff (rst) (enable_ff == 16'h0000) ##1 (enable_ff == 16'h0000) |-> !irqActive;
  endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("irq with all enables off");
  property p_softKeepsEnable;
    @(posedge clk) disable iff (rst) softReset_ff |=> (enable_ff == $past(enable_ff));
  endproperty
  a_softKeepsEnable: assert property (p_softKeepsEnable) else $error("soft reset changed enables");
  property p_softClears;
    @(posedge clk) disable iff (rst) softReset_ff |=> (status_ff == 16'h0000);
  endproperty
  a_softClears: assert property (p_softClears) else $error("soft reset left status");
  property p_latchAneg;
    @(posedge clk) disable iff (rst) anegErrorEvt && !softReset_ff |=> status_ff[BIT_ANEG_ERR];
  endproperty
  a_latchAneg: assert property (p_latchAneg) else $error("aneg error not latched");
  property p_latchLink;
    @(posedge clk) disable iff (rst) lvlChange[3] && !softReset_ff |=> status_ff[BIT_LINK];
  endproperty
  a_latchLink: assert property (p_latchLink) else $error("link change not latched");
  property p_latchSpeed;
    @(posedge clk) disable iff (rst) (|lvlChange[6:5]) && !softReset_ff |=> status_ff[BIT_SPEED];
  endproperty
  a_latchSpeed: assert property (p_latchSpeed) else $error("speed change not latched");
  property p_hold;
    @(posedge clk) disable iff (rst) status_ff[BIT_JABBER] && !statusRead && !softReset_ff |=> status_ff[BIT_JABBER];
  endproperty
  a_hold: assert property (p_hold) else $error("status lost without read");
  property p_readClear;
    @(posedge clk) disable iff (rst) statusRead && !jabberEvt |=> !status_ff[BIT_JABBER];
  endproperty
  a_readClear: assert property (p_readClear) else $error("read did not clear");
  property p_reserved;
    @(posedge clk) disable iff (rst) (status_ff & ~EVENT_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");
  c_write: cover property (@(posedge clk) disable iff (rst) doWrite && awAddr_ff == ENABLE_ADDR);
  c_readStatus: cover property (@(posedge clk) disable iff (rst) statusRead && status_ff != 16'h0000);
  c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irqActive));
endmodule

`default_nettype wire

/* File: copper_phy_interrupt_regs_test.sv */
// Self-checking bench for the copper event enable and status registers
// Assumes the design package and an AXI4-Lite slave on one 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module copper_phy_interrupt_regs_test;
  import copper_irq_pkg::*;
  typedef struct packed {
    logic [15:0] evt;
    logic [15:0] ena;
    logic [15:0] expSt;
    logic expIrq;
  } row_s;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic [15:0] pulseEvt = '0;
  logic [1:0] speedLevel = '0;
  logic duplexLevel = 1'h0;
  logic linkLevel = 1'h0;
  logic crossoverLevel = 1'h0;
  logic energySleepLevel = 1'h0;
  logic polarityLevel = 1'h0;
  logic irqActive;
  logic [31:0] data;
  logic [1:0] resp;
  int errors = 0;
  int checkCount = 0;
  row_s rows [14] = '{
    '{16'h8000, 16'h8000, 16'h8000, 1'h1}, '{16'h4000, 16'hBF5B, 16'h4000, 1'h0},
    '{16'h2000, 16'h2000, 16'h2000, 1'h1}, '{16'h1000, 16'hEF5B, 16'h1000, 1'h0},
    '{16'h0800, 16'h0800, 16'h0800, 1'h1}, '{16'h0400, 16'hFB5B, 16'h0400, 1'h0},
    '{16'h0200, 16'h0200, 16'h0200, 1'h1}, '{16'h0100, 16'hFE5B, 16'h0100, 1'h0},
    '{16'h0040, 16'h0040, 16'h0040, 1'h1}, '{16'h0010, 16'hFF4B, 16'h0010, 1'h0},
    '{16'h0008, 16'h0008, 16'h0008, 1'h1}, '{16'h0002, 16'hFF59, 16'h0002, 1'h0},
    '{16'h0001, 16'h0001, 16'h0001, 1'h1}, '{16'hFF5B, 16'hFF5B, 16'hFF5B, 1'h1}};

  always #12.5 clk = ~clk;

  copper_phy_interrupt_regs copper_phy_interrupt_regs_i (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .anegErrorEvt(pulseEvt[15]), .speedLevel(speedLevel), .duplexLevel(duplexLevel),
    .pageReceivedEvt(pulseEvt[12]), .anegCompleteEvt(pulseEvt[11]), .linkLevel(linkLevel),
    .symbolErrorEvt(pulseEvt[9]), .falseCarrierEvt(pulseEvt[8]), .crossoverLevel(crossoverLevel),
    .energySleepLevel(energySleepLevel), .flpNoLinkEvt(pulseEvt[3]), .polarityLevel(polarityLevel),
    .jabberEvt(pulseEvt[0]), .irqActive(irqActive));

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic closeOut();
    $display("checks %0d, mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic miss(input string what);
    errors++;
    $display("unexpected timeout on %s: expected answer, seen none", what);
    closeOut();
  endtask

  task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic chkResp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------
  // Bus cycles and event stimulus
  // ----------------------------------------
  task automatic axiWrite(input logic [ADDR_W-1:0] addr, input logic [31:0] wd, output logic [1:0] rs);
    int n;
    rs = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= wd;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) miss("write");
    rs = s_axi_bresp;
  endtask

  task automatic axiRead(input logic [ADDR_W-1:0] addr, output logic [31:0] rd, output logic [1:0] rs);
    int n;
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) miss("read");
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // Pulse inputs for one cycle, toggle level inputs, then let the synchronisers settle
  task automatic fire(input logic [15:0] e);
    @(posedge clk);
    pulseEvt <= e & 16'h9B09;
    speedLevel <= speedLevel ^ {1'h0, e[14]};
    duplexLevel <= duplexLevel ^ e[13];
    linkLevel <= linkLevel ^ e[10];
    crossoverLevel <= crossoverLevel ^ e[6];
    energySleepLevel <= energySleepLevel ^ e[4];
    polarityLevel <= polarityLevel ^ e[1];
    @(posedge clk);
    pulseEvt <= 16'h0000;
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    axiRead(ENABLE_ADDR, data, resp);
    chkVal("enable at reset", 32'h00000000, data);
    axiRead(STATUS_ADDR, data, resp);
    chkVal("status at reset", 32'h00000000, data);
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      axiWrite(ENABLE_ADDR, {16'h0000, rows[i].ena}, resp);
      fire(rows[i].evt);
      chkBit("irqActive", rows[i].expIrq, irqActive);
      axiRead(STATUS_ADDR, data, resp);
      chkVal("status", {16'h0000, rows[i].expSt}, data);
      axiRead(STATUS_ADDR, data, resp);
      chkVal("status reread", 32'h00000000, data);
      repeat (2) @(posedge clk);
      chkBit("irqActive after read", 1'h0, irqActive);
    end
    // Event held through a read keeps its bit
    @(posedge clk);
    pulseEvt <= 16'h0001;
    repeat (3) @(posedge clk);
    axiRead(STATUS_ADDR, data, resp);
    axiRead(STATUS_ADDR, data, resp);
    chkVal("status while held", 32'h00000001, data);
    pulseEvt <= 16'h0000;
    axiRead(STATUS_ADDR, data, resp);
    axiRead(STATUS_ADDR, data, resp);
    chkVal("status after release", 32'h00000000, data);
    // Soft reset keeps enables, clears status
    axiWrite(ENABLE_ADDR, 32'h0000FF5B, resp);
    chkResp("enable write resp", RESP_OKAY, resp);
    fire(16'h0001);
    chkBit("irqActive before soft reset", 1'h1, irqActive);
    axiRead(CONTROL_ADDR, data, resp);
    chkVal("global indication pending", 32'h00000002, data);
    axiWrite(CONTROL_ADDR, 32'h00000001, resp);
    repeat (4) @(posedge clk);
    chkBit("irqActive after soft reset", 1'h0, irqActive);
    axiRead(ENABLE_ADDR, data, resp);
    chkVal("enable after soft reset", 32'h0000FF5B, data);
    axiRead(STATUS_ADDR, data, resp);
    chkVal("status after soft reset", 32'h00000000, data);
    axiRead(CONTROL_ADDR, data, resp);
    chkVal("global indication idle", 32'h00000000, data);
    // Unmapped place
    axiRead(8'h00, data, resp);
    chkResp("unmapped read resp", RESP_SLVERR, resp);
    chkVal("unmapped read data", 32'h00000000, data);
    axiWrite(8'h00, 32'h00000001, resp);
    chkResp("unmapped write resp", RESP_SLVERR, resp);
    // Hardware reset in mid-run clears the enables
    fire(16'h8000);
    @(posedge clk);
    rst <= 1'h1;
    linkLevel <= 1'h1;
    repeat (3) @(posedge clk);
    chkBit("irqActive in reset", 1'h0, irqActive);
    chkBit("s_axi_awready in reset", 1'h0, s_axi_awready);
    rst <= 1'h0;
    axiRead(ENABLE_ADDR, data, resp);
    chkVal("enable after hard reset", 32'h00000000, data);
    axiRead(STATUS_ADDR, data, resp);
    chkVal("status after hard reset", 32'h00000000, data);
    closeOut();
  end
endmodule
`default_nettype wire
